//--- verilog/acfg_regs.vh
// Register offsets, field positions, reset values and codes of the converter control block
`ifndef ACFG_REGS_VH
`define ACFG_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define ACFG_ADDR_GLOBAL_CLOCK   8'h09
`define ACFG_ADDR_CLK_DIVIDER    8'h0B
`define ACFG_ADDR_TEST_SELECT    8'h0D
`define ACFG_ADDR_OFFSET_TRIM    8'h10
`define ACFG_ADDR_OUTPUT_FORMAT  8'h14
`define ACFG_ADDR_DRIVE_STRENGTH 8'h15
`define ACFG_ADDR_CLOCK_POLARITY 8'h16
`define ACFG_ADDR_CLOCK_DELAY    8'h17
`define ACFG_ADDR_USER_BASE      8'h19
`define ACFG_ADDR_USER_LAST      8'h20

// ****************************************
// Reset values
// ****************************************
`define ACFG_RST_GLOBAL_CLOCK    8'h01
`define ACFG_RST_CLK_DIVIDER     8'h00
`define ACFG_RST_TEST_SELECT     8'h00
`define ACFG_RST_OFFSET_TRIM     8'h00
`define ACFG_RST_OUTPUT_FORMAT   8'h01
`define ACFG_RST_DRIVE_STRENGTH  8'h01
`define ACFG_RST_CLOCK_POLARITY  8'h00
`define ACFG_RST_CLOCK_DELAY     8'h00
`define ACFG_RST_USER            8'h00

// ****************************************
// Field positions
// ****************************************
`define ACFG_GC_DUTY_BIT         0
`define ACFG_DIV_RATIO_LO        0
`define ACFG_DIV_PHASE_LO        3
`define ACFG_TM_MODE_LO          0
`define ACFG_TM_SHORT_RST_BIT    4
`define ACFG_TM_LONG_RST_BIT     5
`define ACFG_TM_SINGLE_BIT       7
`define ACFG_OF_FORMAT_LO        0
`define ACFG_OF_INVERT_BIT       2
`define ACFG_OF_DISABLE_BIT      4
`define ACFG_CP_INVERT_BIT       7
`define ACFG_CD_SETTING_LO       0
`define ACFG_CD_ENABLE_BIT       7

// ****************************************
// Test mode codes
// ****************************************
`define ACFG_TM_OFF              4'h0
`define ACFG_TM_MIDSCALE         4'h1
`define ACFG_TM_POS_FS           4'h2
`define ACFG_TM_NEG_FS           4'h3
`define ACFG_TM_CHECKER          4'h4
`define ACFG_TM_PN_LONG          4'h5
`define ACFG_TM_PN_SHORT         4'h6
`define ACFG_TM_TOGGLE           4'h7
`define ACFG_TM_USER             4'h8
`define ACFG_TM_RAMP             4'hF

// ****************************************
// Output clock delay timing, picoseconds
// ****************************************
`define ACFG_DLY_BASE_PS         100
`define ACFG_DLY_SPAN_PS         3100
`define ACFG_DLY_STEPS           31

// ****************************************
// Pseudonoise seeds
// ****************************************
`define ACFG_PN_SHORT_SEED       9'h1FF
`define ACFG_PN_LONG_SEED        23'h7F_FFFF

`endif

//--- verilog/acfg_fifo.v
// No logic here; the sample word FIFO module sits beside the top module

//--- verilog/acfg_top.v
// Converter clock setup, output test patterns and output clock delay control
// ****************************************
// Functional notes
// - Mode zero passes converted samples through
// - Codes one-three give midscale, plus, minus full
// - Code four alternates complementary checkerboard words
// - Code five long pseudonoise, own reset bit
// - Code six short pseudonoise, own reset bit
// - Code seven toggles all ones, all zeros
// - Code eight user words; fifteen ramps
// - Clock delay is 100 plus 3100*n/31 ps
// - User word is low byte then high byte
// ****************************************
`timescale 1ns/1ps
`default_nettype none
`include "acfg_regs.vh"

module acfg_top #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Register port
    input  wire [7:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_write,
    output reg  [7:0]       reg_rdata,
    // Converted samples from the core
    input  wire [WIDTH-1:0] core_data,
    input  wire             core_valid,
    output reg              core_ready,
    // Output word stream to the capture logic
    output reg  [WIDTH-1:0] out_word,
    output reg              out_valid,
    input  wire             out_ready,
    // Sample clock, output clock and output format control
    output reg              sample_clk_en,
    output reg              duty_corrector_on,
    output reg              output_data_clock_invert,
    output reg              output_data_clock_delay_on,
    output reg  [15:0]      output_data_clock_delay_ps,
    output reg              output_disable,
    output reg              output_invert,
    output reg  [1:0]       output_format
);
    // ****************************************
    // Registers
    // ****************************************
    reg [7:0]  global_clock_setup_reg;
    reg [7:0]  sample_clock_divider_reg;
    reg [7:0]  output_test_pattern_select_reg;
    reg [7:0]  digital_offset_trim_reg;
    reg [7:0]  output_format_control_reg;
    reg [7:0]  output_drive_strength_reg;
    reg [7:0]  output_clock_polarity_reg;
    reg [7:0]  output_clock_delay_reg;
    reg [7:0]  user_byte_reg [0:7];

    wire [3:0] mode       = output_test_pattern_select_reg[`ACFG_TM_MODE_LO +: 4];
    wire       long_hold  = output_test_pattern_select_reg[`ACFG_TM_LONG_RST_BIT];
    wire       short_hold = output_test_pattern_select_reg[`ACFG_TM_SHORT_RST_BIT];
    wire       single     = output_test_pattern_select_reg[`ACFG_TM_SINGLE_BIT];
    wire [2:0] ratio      = sample_clock_divider_reg[`ACFG_DIV_RATIO_LO +: 3];
    wire [2:0] phase      = sample_clock_divider_reg[`ACFG_DIV_PHASE_LO +: 3];
    wire [4:0] dly_set    = output_clock_delay_reg[`ACFG_CD_SETTING_LO +: 5];
    wire [7:0] user_off   = reg_addr - `ACFG_ADDR_USER_BASE;
    wire       user_hit   = (reg_addr >= `ACFG_ADDR_USER_BASE) &&
                            (reg_addr <= `ACFG_ADDR_USER_LAST);

    integer i;
    always @(posedge clk) begin
        if (!reset_n) begin
            global_clock_setup_reg         <= `ACFG_RST_GLOBAL_CLOCK;
            sample_clock_divider_reg       <= `ACFG_RST_CLK_DIVIDER;
            output_test_pattern_select_reg <= `ACFG_RST_TEST_SELECT;
            digital_offset_trim_reg        <= `ACFG_RST_OFFSET_TRIM;
            output_format_control_reg      <= `ACFG_RST_OUTPUT_FORMAT;
            output_drive_strength_reg      <= `ACFG_RST_DRIVE_STRENGTH;
            output_clock_polarity_reg      <= `ACFG_RST_CLOCK_POLARITY;
            output_clock_delay_reg         <= `ACFG_RST_CLOCK_DELAY;
            for (i = 0; i < 8; i = i + 1) begin
                user_byte_reg[i] <= `ACFG_RST_USER;
            end
        end else if (reg_write) begin
            case (reg_addr)
                `ACFG_ADDR_GLOBAL_CLOCK:   global_clock_setup_reg <= reg_wdata;
                `ACFG_ADDR_CLK_DIVIDER:    sample_clock_divider_reg <= reg_wdata;
                `ACFG_ADDR_TEST_SELECT:    output_test_pattern_select_reg <= reg_wdata;
                `ACFG_ADDR_OFFSET_TRIM:    digital_offset_trim_reg <= reg_wdata;
                `ACFG_ADDR_OUTPUT_FORMAT:  output_format_control_reg <= reg_wdata;
                `ACFG_ADDR_DRIVE_STRENGTH: output_drive_strength_reg <= reg_wdata;
                `ACFG_ADDR_CLOCK_POLARITY: output_clock_polarity_reg <= reg_wdata;
                `ACFG_ADDR_CLOCK_DELAY:    output_clock_delay_reg <= reg_wdata;
                default: begin
                    if (user_hit) begin
                        user_byte_reg[user_off[2:0]] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    // Reads take one cycle; unmapped offsets read zero
    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `ACFG_ADDR_GLOBAL_CLOCK:   reg_rdata <= global_clock_setup_reg;
                `ACFG_ADDR_CLK_DIVIDER:    reg_rdata <= sample_clock_divider_reg;
                `ACFG_ADDR_TEST_SELECT:    reg_rdata <= output_test_pattern_select_reg;
                `ACFG_ADDR_OFFSET_TRIM:    reg_rdata <= digital_offset_trim_reg;
                `ACFG_ADDR_OUTPUT_FORMAT:  reg_rdata <= output_format_control_reg;
                `ACFG_ADDR_DRIVE_STRENGTH: reg_rdata <= output_drive_strength_reg;
                `ACFG_ADDR_CLOCK_POLARITY: reg_rdata <= output_clock_polarity_reg;
                `ACFG_ADDR_CLOCK_DELAY:    reg_rdata <= output_clock_delay_reg;
                default:                   reg_rdata <= user_hit ?
                                                        user_byte_reg[user_off[2:0]] : 8'h00;
            endcase
        end
    end

    // ****************************************
    // Sample clock divider
    // ****************************************
    // Phase delay holds the divider after each ratio write, so it restarts aligned
    reg [2:0] div_cnt_reg;
    reg [2:0] phase_cnt_reg;
    wire      div_write = reg_write && (reg_addr == `ACFG_ADDR_CLK_DIVIDER);

    always @(posedge clk) begin
        if (!reset_n) begin
            div_cnt_reg       <= 3'h0;
            phase_cnt_reg     <= 3'h0;
            sample_clk_en     <= 1'b0;
            duty_corrector_on <= 1'b1;
        end else begin
            duty_corrector_on <= global_clock_setup_reg[`ACFG_GC_DUTY_BIT] ||
                                 (ratio != 3'h0);
            if (div_write) begin
                phase_cnt_reg <= reg_wdata[`ACFG_DIV_PHASE_LO +: 3];
                div_cnt_reg   <= 3'h0;
                sample_clk_en <= 1'b0;
            end else if (phase_cnt_reg != 3'h0) begin
                phase_cnt_reg <= phase_cnt_reg - 3'h1;
                sample_clk_en <= 1'b0;
            end else if (div_cnt_reg >= ratio) begin
                div_cnt_reg   <= 3'h0;
                sample_clk_en <= 1'b1;
            end else begin
                div_cnt_reg   <= div_cnt_reg + 3'h1;
                sample_clk_en <= 1'b0;
            end
        end
    end

    // ****************************************
    // Pattern generators
    // ****************************************
    reg [8:0]       pn_short_reg;
    reg [22:0]      pn_long_reg;
    reg             alt_reg;
    reg [1:0]       user_idx_reg;
    reg             user_done_reg;
    reg [WIDTH-1:0] ramp_reg;
    reg [WIDTH-1:0] pattern;
    reg             mode_valid;
    wire            fifo_in_ready;
    wire            step = sample_clk_en && fifo_in_ready;
    wire [15:0]     user_word = {user_byte_reg[{user_idx_reg, 1'b1}],
                                 user_byte_reg[{user_idx_reg, 1'b0}]};
    wire            mode_write = reg_write && (reg_addr == `ACFG_ADDR_TEST_SELECT);

    always @(posedge clk) begin
        if (!reset_n) begin
            pn_short_reg  <= `ACFG_PN_SHORT_SEED;
            pn_long_reg   <= `ACFG_PN_LONG_SEED;
            alt_reg       <= 1'b0;
            user_idx_reg  <= 2'h0;
            user_done_reg <= 1'b0;
            ramp_reg      <= {WIDTH{1'b0}};
        end else begin
            if (short_hold) begin
                pn_short_reg <= `ACFG_PN_SHORT_SEED;
            end else if (step && mode == `ACFG_TM_PN_SHORT) begin
                pn_short_reg <= {pn_short_reg[7:0],
                                 pn_short_reg[8] ^ pn_short_reg[4]};
            end
            if (long_hold) begin
                pn_long_reg <= `ACFG_PN_LONG_SEED;
            end else if (step && mode == `ACFG_TM_PN_LONG) begin
                pn_long_reg <= {pn_long_reg[21:0],
                                pn_long_reg[22] ^ pn_long_reg[17]};
            end
            if (mode_write) begin
                user_idx_reg  <= 2'h0;
                user_done_reg <= 1'b0;
            end else if (step) begin
                alt_reg  <= ~alt_reg;
                ramp_reg <= ramp_reg + 1'b1;
                if (mode == `ACFG_TM_USER) begin
                    user_idx_reg <= user_idx_reg + 2'h1;
                    if (single && user_idx_reg == 2'h3) begin
                        user_done_reg <= 1'b1;
                    end
                end
            end
        end
    end

    always @* begin
        pattern    = {WIDTH{1'b0}};
        mode_valid = 1'b1;
        case (mode)
            `ACFG_TM_OFF:      pattern = core_data;
            `ACFG_TM_MIDSCALE: pattern = {WIDTH{1'b0}};
            `ACFG_TM_POS_FS:   pattern = {1'b0, {(WIDTH-1){1'b1}}};
            `ACFG_TM_NEG_FS:   pattern = {1'b1, {(WIDTH-1){1'b0}}};
            `ACFG_TM_CHECKER:  pattern = {(WIDTH/2){alt_reg, ~alt_reg}};
            `ACFG_TM_PN_LONG:  pattern = pn_long_reg[WIDTH-1:0];
            `ACFG_TM_PN_SHORT: pattern = {pn_short_reg, pn_short_reg[WIDTH-10:0]};
            `ACFG_TM_TOGGLE:   pattern = {WIDTH{alt_reg}};
            `ACFG_TM_USER:     pattern = user_done_reg ? {WIDTH{1'b0}} :
                                         user_word[15:16-WIDTH];
            `ACFG_TM_RAMP:     pattern = ramp_reg;
            default:           mode_valid = 1'b0;
        endcase
    end

    // Normal mode consumes a core sample per divided clock; the core must hold data
    wire            normal   = (mode == `ACFG_TM_OFF);
    wire            fifo_in_valid = sample_clk_en && mode_valid && (!normal || core_valid);
    wire [WIDTH-1:0] fifo_out_data;
    wire            fifo_out_valid;
    wire            take_out = fifo_out_valid && (out_ready || !out_valid);

    // Whole picoseconds; integer division drops the fraction of a step
    wire [31:0]     dly_ps_full = `ACFG_DLY_BASE_PS +
                                  (`ACFG_DLY_SPAN_PS * dly_set) / `ACFG_DLY_STEPS;

    always @(posedge clk) begin
        if (!reset_n) begin
            core_ready <= 1'b0;
        end else begin
            core_ready <= fifo_in_ready && normal;
        end
    end

    acfg_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_data   (pattern),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (take_out)
    );

    // ****************************************
    // Output stage
    // ****************************************
    always @(posedge clk) begin
        if (!reset_n) begin
            out_word  <= {WIDTH{1'b0}};
            out_valid <= 1'b0;
        end else if (out_ready || !out_valid) begin
            out_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                out_word <= fifo_out_data;
            end
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            output_data_clock_invert   <= 1'b0;
            output_data_clock_delay_on <= 1'b0;
            output_data_clock_delay_ps <= 16'h0000;
            output_disable             <= 1'b0;
            output_invert              <= 1'b0;
            output_format              <= 2'h1;
        end else begin
            output_data_clock_invert   <= output_clock_polarity_reg[`ACFG_CP_INVERT_BIT];
            output_data_clock_delay_on <= output_clock_delay_reg[`ACFG_CD_ENABLE_BIT];
            output_data_clock_delay_ps <= dly_ps_full[15:0];
            output_disable <= output_format_control_reg[`ACFG_OF_DISABLE_BIT];
            output_invert  <= output_format_control_reg[`ACFG_OF_INVERT_BIT];
            output_format  <= output_format_control_reg[`ACFG_OF_FORMAT_LO +: 2];
        end
    end
endmodule

module acfg_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      count_reg;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = ({{(31-AW){1'b0}}, count_reg} != DEPTH);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_reg];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            wr_reg    <= {AW{1'b0}};
            rd_reg    <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/acfg_top_monitor.sv
// Checker of register effects, divider cadence and stream hold
`timescale 1ns/1ps
`default_nettype none
module acfg_top_monitor #(
    parameter WIDTH = 14
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // Register port
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_write,
    input wire logic [7:0]       reg_rdata,
    // Output stream
    input wire logic [WIDTH-1:0] out_word,
    input wire logic             out_valid,
    input wire logic             out_ready,
    // Clock and output control
    input wire logic             sample_clk_en,
    input wire logic             duty_corrector_on,
    input wire logic             output_data_clock_invert,
    input wire logic             output_data_clock_delay_on,
    input wire logic [15:0]      output_data_clock_delay_ps,
    input wire logic             output_disable,
    input wire logic             output_invert,
    input wire logic [1:0]       output_format
);
    default clocking dck @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ****************************************
    // Shadow of clock settings
    // ****************************************
    logic [2:0] div_ratio;
    logic [2:0] gap;
    logic [1:0] seen;
    logic       gc_bit;
    wire        wr_div = reg_write && reg_addr == 8'h0B;
    wire        unmapped = !(reg_addr inside {8'h09, 8'h0B, 8'h0D, 8'h10, [8'h14:8'h17],
                                              [8'h19:8'h20]});
    // Divider restarts on a write; spacing judged from the third pulse
    always @(posedge clk) begin
        if (!reset_n) begin
            div_ratio <= 3'h0;
            gap       <= 3'h0;
            seen      <= 2'h0;
            gc_bit    <= 1'b1;
        end else begin
            if (wr_div)
                div_ratio <= reg_wdata[2:0];
            if (reg_write && reg_addr == 8'h09)
                gc_bit <= reg_wdata[0];
            if (sample_clk_en)
                gap <= 3'h0;
            else if (gap != 3'h7)
                gap <= gap + 3'h1;
            if (wr_div)
                seen <= 2'h0;
            else if (sample_clk_en && seen != 2'h2)
                seen <= seen + 2'h1;
        end
    end
    property p_dly;
        logic [7:0] v;
        (reg_write && reg_addr == 8'h17, v = reg_wdata) |-> ##2 output_data_clock_delay_on == v[7]
            && output_data_clock_delay_ps == 100 + 3100 * v[4:0] / 31;
    endproperty
    property p_fmt;
        logic [7:0] v;
        (reg_write && reg_addr == 8'h14, v = reg_wdata) |-> ##2 output_format == v[1:0]
            && output_invert == v[2] && output_disable == v[4];
    endproperty
    property p_pol;
        logic [7:0] v;
        (reg_write && reg_addr == 8'h16, v = reg_wdata) |-> ##2 output_data_clock_invert == v[7];
    endproperty
    property p_dc;
        !reg_write ##1 !reg_write |-> duty_corrector_on == (gc_bit || div_ratio != 3'h0);
    endproperty
    property p_dcw;
        wr_div && reg_wdata[2:0] != 3'h0 |-> ##2 duty_corrector_on;
    endproperty
    property p_div;
        sample_clk_en && seen == 2'h2 |-> gap == div_ratio;
    endproperty
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_word);
    endproperty
    property p_unmap;
        unmapped |=> reg_rdata == 8'h00;
    endproperty
    a_dly: assert property (p_dly) else $error("clock delay output wrong");
    a_fmt: assert property (p_fmt) else $error("output mode fields wrong");
    a_pol: assert property (p_pol) else $error("clock invert wrong");
    a_dc: assert property (p_dc) else $error("duty corrector state wrong");
    a_dcw: assert property (p_dcw) else $error("divider did not force corrector");
    a_div: assert property (p_div) else $error("sample pulse spacing wrong");
    a_hold: assert property (p_hold) else $error("stalled word not held");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    c_div: cover property (sample_clk_en && seen == 2'h2 && div_ratio == 3'h2);
    c_stall: cover property (out_valid && !out_ready);
    c_dly: cover property (reg_write && reg_addr == 8'h17);
endmodule
bind acfg_top acfg_top_monitor #(.WIDTH(WIDTH)) i_mon (.*);
`default_nettype wire

//--- tb/acfg_capture.sv
// Capture logic model taking sample words from the output stream
`timescale 1ns/1ps
`default_nettype none
module acfg_capture #(
    parameter WIDTH = 14
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Stream from the block
    input  wire logic [WIDTH-1:0] out_word,
    input  wire logic             out_valid,
    output var  logic             out_ready,
    // Stall control and captured result
    input  wire logic             stall,
    output var  logic [WIDTH-1:0] got_word,
    output var  logic [31:0]      got_count
);
    // Ready changes only after an edge
    always @(posedge clk) begin
        if (!reset_n) begin
            out_ready <= 1'b0;
            got_word  <= '0;
            got_count <= 32'h0000_0000;
        end else begin
            out_ready <= !stall;
            if (out_valid && out_ready) begin
                got_word  <= out_word;
                got_count <= got_count + 32'h0000_0001;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, core_valid = 1'b0, stall = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [13:0] core_data = 14'h1234;
    wire  [7:0]  reg_rdata;
    wire  [13:0] out_word, got_word;
    wire  [31:0] got_count;
    wire  [15:0] output_data_clock_delay_ps;
    wire  [1:0]  output_format;
    wire         core_ready, out_valid, out_ready, sample_clk_en, duty_corrector_on;
    wire         output_data_clock_invert, output_data_clock_delay_on, output_disable;
    wire         output_invert;
    int          failures = 0, n_compared = 0;
    always #25 clk = ~clk;
    acfg_top i_dut (.*);
    acfg_capture i_cap (.*);
    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task chk(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task nw(output logic [13:0] w);
        logic [31:0] c0;
        c0 = got_count;
        repeat (300) if (got_count === c0) @(negedge clk);
        chk(got_count, c0 + 1);
        w = got_word;
    endtask
    // Mode zero with no core words lets the FIFO drain
    task set_mode(input logic [7:0] m);
        wr(8'h0D, 8'h00);
        repeat (40) @(negedge clk);
        wr(8'h0D, m);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        logic [7:0]  d;
        logic [15:0] p [9] = '{16'h0901, 16'h0B00, 16'h0D00, 16'h1000, 16'h1401, 16'h1501,
                               16'h1600, 16'h1700, 16'h3000};
        chk({duty_corrector_on, output_format, out_valid}, 4'hA);
        for (int k = 0; k < 9; k++) begin
            rd(p[k][15:8], d);
            chk(d, p[k][7:0]);
        end
        wr(8'h15, 8'h07);
        wr(8'h30, 8'h55);
        rd(8'h15, d);
        chk(d, 8'h07);
        rd(8'h30, d);
        chk(d, 8'h00);
    endtask
    task t_dly;
        for (int n = 0; n < 32; n++) begin
            wr(8'h17, 8'h80 | 8'(n));
            @(negedge clk);
            chk({output_data_clock_delay_on, output_data_clock_delay_ps},
                17'h1_0000 + 100 + 3100 * n / 31);
        end
        wr(8'h16, 8'h80);
        wr(8'h14, 8'h16);
        wr(8'h17, 8'h00);
        @(negedge clk);
        chk({output_data_clock_invert, output_disable, output_invert, output_format,
             output_data_clock_delay_on}, 6'h3C);
        wr(8'h16, 8'h00);
        wr(8'h14, 8'h01);
    endtask
    task t_div;
        int n;
        wr(8'h09, 8'h00);
        wr(8'h0B, 8'h00);
        repeat (2) @(negedge clk);
        chk(duty_corrector_on, 1'b0);
        wr(8'h0B, 8'h12);
        repeat (2) @(negedge clk);
        chk(duty_corrector_on, 1'b1);
        repeat (10) @(negedge clk);
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if (sample_clk_en === 1'b1)
                n++;
        end
        chk(n, 10);
        wr(8'h0B, 8'h00);
        wr(8'h09, 8'h01);
    endtask
    task automatic t_patterns;
        logic [13:0] a, b;
        logic [7:0]  m [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0F};
        logic [13:0] e [3] = '{14'h0000, 14'h1FFF, 14'h2000};
        for (int k = 0; k < 6; k++) begin
            set_mode(m[k]);
            nw(a);
            nw(b);
            if (k < 3)
                chk(b, e[k]);
            else if (k < 5)
                chk(a ^ b, 14'h3FFF);
            else
                chk(b, 14'(a + 14'h0001));
            if (k == 4)
                chk(a === 14'h0000 || a === 14'h3FFF, 1'b1);
        end
    endtask
    task automatic t_pn;
        logic [13:0] a, b;
        int ch;
        logic [7:0] m [2] = '{8'h25, 8'h16};
        for (int k = 0; k < 2; k++) begin
            set_mode(m[k]);
            nw(a);
            repeat (4) begin
                nw(b);
                chk(b, a);
            end
            wr(8'h0D, m[k] & 8'h0F);
            repeat (20) nw(b);
            ch = 0;
            repeat (8) begin
                nw(a);
                if (a !== b)
                    ch++;
                b = a;
            end
            chk(ch > 0, 1'b1);
        end
    endtask
    task t_user;
        logic [15:0] u [4];
        logic [13:0] w;
        logic [7:0]  d;
        for (int n = 0; n < 4; n++) begin
            u[n] = 16'h8E4B + 16'h1357 * n;
            wr(8'(8'h19 + 2 * n), u[n][7:0]);
            wr(8'(8'h1A + 2 * n), u[n][15:8]);
        end
        rd(8'h1C, d);
        chk(d, u[1][15:8]);
        set_mode(8'h88);
        for (int n = 0; n < 6; n++) begin
            nw(w);
            chk(w, n < 4 ? u[n][15:2] : 14'h0000);
        end
        set_mode(8'h08);
        for (int n = 0; n < 6; n++) begin
            nw(w);
            chk(w, u[n % 4][15:2]);
        end
    endtask
    task t_normal;
        logic [13:0] w;
        int cnt;
        set_mode(8'h00);
        core_valid = 1'b1;
        nw(w);
        chk({w, core_ready}, 15'h2469);
        stall = 1'b1;
        repeat (40) @(negedge clk);
        chk({core_ready, out_valid}, 2'h1);
        core_valid = 1'b0;
        stall = 1'b0;
        cnt = 0;
        repeat (40) begin
            @(negedge clk);
            if (out_valid === 1'b1 && out_ready === 1'b1)
                cnt++;
        end
        chk({cnt >= 16, out_valid, got_word}, 16'h9234);
    endtask
    task test_done;
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        t_regs;
        t_dly;
        t_div;
        t_patterns;
        t_pn;
        t_user;
        t_normal;
        test_done;
    end
    // Tests take about a thousand cycles
    initial begin
        #(50 * 20000);
        failures++;
        test_done;
    end
endmodule
`default_nettype wire
